/* design/mbp_pkg.sv */
// shared constants and carrier types for the mode programmable byte port
package mbp_pkg;

  // ==========================================================================
  // widths and depths
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 32;
  localparam int unsigned FIFO_AW     = 5;

  // ==========================================================================
  // mode encoding
  localparam logic MODE_INPUT  = 1'h0;
  localparam logic MODE_OUTPUT = 1'h1;

  // ==========================================================================
  // reset values and request event values
  localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;
  localparam logic              SR_CLR_INPUT  = 1'h1;
  localparam logic              SR_CLR_OUTPUT = 1'h0;
  localparam logic              SR_IDLE_INPUT = 1'h1;
  localparam logic              SR_SET_OUTPUT = 1'h1;
  localparam logic              SR_ACT_INPUT  = 1'h0;
  localparam logic              SR_ACT_OUTPUT = 1'h0;

  // ==========================================================================
  // pin bundle, reset state of the synchroniser
  typedef struct packed {
    logic              strobe;
    logic              select_first;
    logic              select_second;
    logic              clear_n;
    logic              mode;
    logic [DATA_W-1:0] byte_in_bus;
  } mbp_pins_s;

  localparam mbp_pins_s PINS_RESET = '{strobe: 1'h0, select_first: 1'h0, select_second: 1'h0,
                                       clear_n: 1'h1, mode: 1'h0, byte_in_bus: 8'h00};

  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_RUN
  } mbp_state_e;

endpackage : mbp_pkg

/* design/mbp_mem.sv */
// simple dual port memory with registered read data and write bypass
`timescale 1ns/1ps
module mbp_mem
  import mbp_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = 5
) (
  // clock
  input  wire logic             clock_in,
  // write side
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // read side
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] store_q [DEPTH];

  // ==========================================================================
  // storage
  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      store_q[wr_addr_in] <= wr_data_in;
    end
  end

  // ==========================================================================
  // read register, newest write seen at once
  always_ff @(posedge clock_in) begin
    if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
      rd_data_out <= wr_data_in;
    end else begin
      rd_data_out <= store_q[rd_addr_in];
    end
  end

endmodule : mbp_mem

/* design/mbp_fifo.sv */
// show-ahead fifo with valid and ready on both sides
`timescale 1ns/1ps
module mbp_fifo
  import mbp_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = 5
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             resetn_in,
  // filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  wire           push;
  wire           pop;
  wire [AW-1:0]  rd_addr;

  // ==========================================================================
  // flags and strobes
  assign in_ready_out  = (count_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_out = (count_q != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign rd_addr       = pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;

  // ==========================================================================
  // pointers and fill count
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
      rd_ptr_q <= rd_addr;
      count_q  <= (AW+1)'(count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

  mbp_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clock_in    (clock_in),
    .wr_en_in    (push),
    .wr_addr_in  (wr_ptr_q),
    .wr_data_in  (in_data_in),
    .rd_addr_in  (rd_addr),
    .rd_data_out (out_data_out)
  );

endmodule : mbp_fifo

/* design/mbp_port.sv */
// mode programmable byte port with service request handshake
// Operation
// - mode pin picks input or output role
// - drive service request from handshake flip-flop
// - input mode: register follows data while strobe high
// - input mode: strobe fall freezes, request low
// - input mode: both selects high drive outputs
// - input mode: deselect floats outputs, request high
// - output mode: drivers always enabled
// - output mode: write window passes byte, fall holds
// - output mode: deselect raises request, fall lowers
// - clear zeroes register, request per mode
`timescale 1ns/1ps
module mbp_port
  import mbp_pkg::*;
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              resetn_in,
  // processor and peripheral pins
  input  wire logic              strobe_in,
  input  wire logic              select_first_in,
  input  wire logic              select_second_in,
  input  wire logic              clear_n_in,
  input  wire logic              mode_in,
  input  wire logic [DATA_W-1:0] byte_in_bus_in,
  // port outputs
  output logic      [DATA_W-1:0] byte_out_bus_out,
  output logic                   byte_out_en_n_out,
  output logic                   service_request_out,
  // captured byte stream
  output logic                   capture_ready_out,
  output logic                   capture_valid_out,
  input  wire logic              capture_ready_in,
  output logic      [DATA_W-1:0] capture_data_out,
  output logic                   capture_overflow_out
);

  // synchroniser stages
  mbp_pins_s         pins_raw;
  mbp_pins_s         pins_meta_q;
  mbp_pins_s         pins_q;
  // event history
  logic              strobe_prev_q;
  logic              deselect_prev_q;
  logic              write_prev_q;
  // register, request and enable
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] data_d;
  logic              sr_q;
  logic              sr_d;
  logic              oe_n_q;
  logic              oe_n_d;
  // capture and sequencing
  logic              overflow_q;
  mbp_state_e        state_q;

  // decode
  wire strobe_fall;
  wire both_selected;
  wire write_select;
  wire write_window;
  wire deselected;
  wire deselect_edge;
  wire output_mode;
  wire run_state;
  wire clearing;
  wire follow;
  wire sr_clear_value;
  // capture stream
  wire push;
  wire fifo_ready;
  wire fifo_full;
  wire overflow_set;

  // ==========================================================================
  // pin synchroniser
  assign pins_raw = '{strobe: strobe_in, select_first: select_first_in, select_second: select_second_in,
                      clear_n: clear_n_in, mode: mode_in, byte_in_bus: byte_in_bus_in};

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pins_meta_q <= PINS_RESET;
    end else begin
      pins_meta_q <= pins_raw;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pins_q <= PINS_RESET;
    end else begin
      pins_q <= pins_meta_q;
    end
  end

  // ==========================================================================
  // mode and select decode
  // mode select
  assign output_mode   = (pins_q.mode == MODE_OUTPUT);
  assign both_selected = pins_q.select_first && pins_q.select_second;
  assign write_select  = !pins_q.select_first && pins_q.select_second;
  assign write_window  = write_select && pins_q.strobe;
  assign deselected    = output_mode ? !write_select : !both_selected;

  // ==========================================================================
  // events
  // strobe fall detect
  assign strobe_fall   = strobe_prev_q && !pins_q.strobe;
  assign deselect_edge = deselected && !deselect_prev_q;
  assign run_state     = (state_q == ST_RUN);
  assign clearing      = !pins_q.clear_n || !run_state;

  // ==========================================================================
  // register load and request clear value
  // follow in input mode
  assign follow         = output_mode ? write_window : pins_q.strobe;
  assign sr_clear_value = output_mode ? SR_CLR_OUTPUT : SR_CLR_INPUT;

  // ==========================================================================
  // capture stream decode
  assign push          = strobe_fall && (!output_mode || write_prev_q) && !clearing;
  assign fifo_full     = !fifo_ready;
  assign overflow_set  = push && fifo_full;

  // ==========================================================================
  // holding register
  always_comb begin
    data_d = data_q;
    if (!pins_q.clear_n) begin
      data_d = DATA_RESET;
    end else if (follow) begin
      data_d = pins_q.byte_in_bus;
    end
  end

  // ==========================================================================
  // service request flip-flop
  always_comb begin
    sr_d = sr_q;
    if (!pins_q.clear_n) begin
      sr_d = sr_clear_value;
    end else if (output_mode) begin
      if (deselect_edge) begin
        sr_d = SR_SET_OUTPUT;
      end else if (strobe_fall) begin
        sr_d = SR_ACT_OUTPUT;
      end
    end else begin
      if (strobe_fall) begin
        sr_d = SR_ACT_INPUT;
      end else if (deselect_edge) begin
        sr_d = SR_IDLE_INPUT;
      end
    end
  end

  // ==========================================================================
  // output enable
  always_comb begin
    if (output_mode) begin
      oe_n_d = 1'b0;
    end else if (both_selected) begin
      oe_n_d = 1'b0;
    end else begin
      oe_n_d = 1'b1;
    end
  end

  // ==========================================================================
  // clear sequencer
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_CLEAR;
    end else begin
      case (state_q)
        ST_CLEAR: state_q <= ST_RUN;
        ST_RUN:   state_q <= ST_RUN;
        default:  state_q <= ST_CLEAR;
      endcase
    end
  end

  // ==========================================================================
  // event history
  // previous strobe level
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= pins_q.strobe;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      deselect_prev_q <= 1'b1;
    end else begin
      deselect_prev_q <= deselected;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      write_prev_q <= 1'b0;
    end else begin
      write_prev_q <= write_window;
    end
  end

  // ==========================================================================
  // holding register flop
  // zero after reset
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_q <= DATA_RESET;
    end else if (!run_state) begin
      data_q <= DATA_RESET;
    end else begin
      data_q <= data_d;
    end
  end

  // ==========================================================================
  // service request flop
  // handshake flip-flop
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sr_q <= SR_CLR_INPUT;
    end else if (!run_state) begin
      sr_q <= sr_clear_value;
    end else begin
      sr_q <= sr_d;
    end
  end

  // ==========================================================================
  // output enable flop
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= oe_n_d;
    end
  end

  // ==========================================================================
  // captured byte buffer
  mbp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock_in      (clock_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (data_q),
    .out_valid_out (capture_valid_out),
    .out_ready_in  (capture_ready_in),
    .out_data_out  (capture_data_out)
  );

  // ==========================================================================
  // overflow flag, set wins over clear
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      overflow_q <= 1'b0;
    end else if (overflow_set) begin
      overflow_q <= 1'b1;
    end else if (!pins_q.clear_n) begin
      overflow_q <= 1'b0;
    end
  end

  // ==========================================================================
  // port pin outputs
  // request pin from flip-flop
  assign service_request_out  = sr_q;
  assign byte_out_bus_out     = data_q;
  assign byte_out_en_n_out    = oe_n_q;

  // ==========================================================================
  // capture stream outputs
  assign capture_ready_out    = fifo_ready;
  assign capture_overflow_out = overflow_q;

endmodule : mbp_port

/* test/mbp_port_checker.sv */
// concurrent checks on the pins of the byte port
`timescale 1ns/1ps
module mbp_port_checker
  import mbp_pkg::*;
(
  // clock and reset
  input wire logic              clock_in,
  input wire logic              resetn_in,
  // pins
  input wire logic              strobe_in,
  input wire logic              select_first_in,
  input wire logic              select_second_in,
  input wire logic              clear_n_in,
  input wire logic              mode_in,
  input wire logic [DATA_W-1:0] byte_in_bus_in,
  // outputs
  input wire logic [DATA_W-1:0] byte_out_bus_out,
  input wire logic              byte_out_en_n_out,
  input wire logic              service_request_out
);
  // ==========================================================================
  // select decode
  wire logic in_sel  = select_first_in && select_second_in;
  wire logic out_sel = !select_first_in && select_second_in;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  // ==========================================================================
  // input mode
  property p_in_follow; (!mode_in && strobe_in && clear_n_in && $stable(byte_in_bus_in))[*3]
    |=> byte_out_bus_out == $past(byte_in_bus_in); endproperty
  a_in_follow: assert property (p_in_follow) else $error("byte not followed");
  property p_in_hold; (!mode_in && !strobe_in && clear_n_in)[*4] |=> $stable(byte_out_bus_out); endproperty
  a_in_hold: assert property (p_in_hold) else $error("byte not held");
  property p_in_req; (!mode_in && clear_n_in && !in_sel && strobe_in)[*3]
    ##1 (!mode_in && clear_n_in && !in_sel && !strobe_in)[*4] |=> !service_request_out; endproperty
  a_in_req: assert property (p_in_req) else $error("request not low after strobe");
  property p_in_drive; (!mode_in && in_sel)[*4] |=> !byte_out_en_n_out; endproperty
  a_in_drive: assert property (p_in_drive) else $error("drivers off while selected");
  property p_in_float; (!mode_in && !in_sel)[*4] |=> byte_out_en_n_out; endproperty
  a_in_float: assert property (p_in_float) else $error("drivers on while deselected");

  // ==========================================================================
  // output mode and clear
  property p_out_drive; mode_in[*4] |=> !byte_out_en_n_out; endproperty
  a_out_drive: assert property (p_out_drive) else $error("drivers off in output mode");
  property p_out_write; (mode_in && out_sel && strobe_in && clear_n_in && $stable(byte_in_bus_in))[*3]
    |=> byte_out_bus_out == $past(byte_in_bus_in); endproperty
  a_out_write: assert property (p_out_write) else $error("write not passed");
  property p_out_rise; (mode_in && clear_n_in && !strobe_in && out_sel)[*3]
    ##1 (mode_in && clear_n_in && !strobe_in && !out_sel)[*4] |=> service_request_out; endproperty
  a_out_rise: assert property (p_out_rise) else $error("request not high on deselect");
  property p_out_fall; (mode_in && clear_n_in && !out_sel && strobe_in)[*3]
    ##1 (mode_in && clear_n_in && !out_sel && !strobe_in)[*4] |=> !service_request_out; endproperty
  a_out_fall: assert property (p_out_fall) else $error("request not low after strobe");
  property p_clear; (!clear_n_in && $stable(mode_in))[*4] |=> byte_out_bus_out == DATA_RESET
    && service_request_out == (mode_in ? SR_CLR_OUTPUT : SR_CLR_INPUT); endproperty
  a_clear: assert property (p_clear) else $error("clear state wrong");
endmodule : mbp_port_checker

/* test/mbp_far_model.sv */
// far side: peripheral or processor driving strobe, selects and data
`timescale 1ns/1ps
module mbp_far_model
  import mbp_pkg::*;
(
  // clock
  input  wire logic              clock_in,
  // pins toward the port
  output logic                   strobe_out,
  output logic                   select_first_out,
  output logic                   select_second_out,
  output logic      [DATA_W-1:0] byte_out
);
  initial begin
    strobe_out = 1'h0;
    select_first_out = 1'h0;
    select_second_out = 1'h0;
    byte_out = 8'h00;
  end

  task automatic wcyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wcyc

  task automatic select(input logic f, input logic s);
    select_first_out = f;
    select_second_out = s;
    wcyc(4);
  endtask : select

  task automatic strobe_up(input logic [DATA_W-1:0] d);
    byte_out = d;
    strobe_out = 1'h1;
    wcyc(4);
  endtask : strobe_up

  task automatic strobe_down();
    strobe_out = 1'h0;
    wcyc(4);
    byte_out = ~byte_out;
    wcyc(1);
  endtask : strobe_down
endmodule : mbp_far_model

/* test/tb_top.sv */
// testbench for the byte port
`timescale 1ns/1ps
module tb_top
  import mbp_pkg::*;
;
  logic              clock_in = 1'h0;
  logic              resetn_in = 1'h0;
  logic              clear_n = 1'h1;
  logic              mode = 1'h0;
  logic              cap_take = 1'h0;
  logic              strobe, sel1, sel2, en_n, sr, cap_rdy, cap_vld, ovf;
  logic [DATA_W-1:0] din, dout, cap_data;
  int                n_errors = 0;
  int                checks = 0;
  int                cycles = 0;

  mbp_far_model far (.clock_in(clock_in), .strobe_out(strobe), .select_first_out(sel1),
    .select_second_out(sel2), .byte_out(din));
  mbp_port dut (.clock_in(clock_in), .resetn_in(resetn_in), .strobe_in(strobe), .select_first_in(sel1),
    .select_second_in(sel2), .clear_n_in(clear_n), .mode_in(mode), .byte_in_bus_in(din),
    .byte_out_bus_out(dout), .byte_out_en_n_out(en_n), .service_request_out(sr),
    .capture_ready_out(cap_rdy), .capture_valid_out(cap_vld), .capture_ready_in(cap_take),
    .capture_data_out(cap_data), .capture_overflow_out(ovf));

  always #10 clock_in = ~clock_in;

  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wcyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wcyc

  task automatic pop_check(input logic [7:0] exp);
    check("cap_vld", 8'(cap_vld), 8'h01);
    check("cap_data", cap_data, exp);
    cap_take = 1'h1;
    wcyc(1);
    cap_take = 1'h0;
    wcyc(1);
  endtask : pop_check

  task automatic clear_pulse(input logic m);
    clear_n = 1'h0;
    mode = m;
    wcyc(4);
    check("dout", dout, DATA_RESET);
    check("sr", 8'(sr), 8'(m ? SR_CLR_OUTPUT : SR_CLR_INPUT));
    clear_n = 1'h1;
    wcyc(4);
  endtask : clear_pulse

  task automatic t_reset_values();
    check("dout", dout, 8'h00);
    check("en_n", 8'(en_n), 8'h01);
    check("sr", 8'(sr), 8'h01);
    check("cap_vld", 8'(cap_vld), 8'h00);
    check("ovf", 8'(ovf), 8'h00);
  endtask : t_reset_values

  task automatic t_input_mode();
    far.strobe_up(8'ha5);
    check("dout", dout, 8'ha5);
    check("sr", 8'(sr), 8'h01);
    far.strobe_down();
    check("sr", 8'(sr), 8'h00);
    check("en_n", 8'(en_n), 8'h01);
    far.select(1'h1, 1'h1);
    check("en_n", 8'(en_n), 8'h00);
    check("dout", dout, 8'ha5);
    far.select(1'h0, 1'h1);
    check("en_n", 8'(en_n), 8'h01);
    check("sr", 8'(sr), 8'h01);
    pop_check(8'ha5);
  endtask : t_input_mode

  task automatic t_output_mode();
    clear_pulse(MODE_OUTPUT);
    far.select(1'h0, 1'h1);
    check("en_n", 8'(en_n), 8'h00);
    far.strobe_up(8'h3c);
    check("dout", dout, 8'h3c);
    far.strobe_down();
    check("dout", dout, 8'h3c);
    far.select(1'h1, 1'h1);
    check("sr", 8'(sr), 8'h01);
    check("en_n", 8'(en_n), 8'h00);
    far.strobe_up(8'hc3);
    check("dout", dout, 8'h3c);
    far.strobe_down();
    check("sr", 8'(sr), 8'h00);
    pop_check(8'h3c);
    check("cap_vld", 8'(cap_vld), 8'h00);
  endtask : t_output_mode

  task automatic t_fifo_fill();
    far.select(1'h0, 1'h0);
    clear_pulse(MODE_INPUT);
    for (int i = 0; i < 33; i++) begin
      far.strobe_up(8'(i));
      far.strobe_down();
    end
    check("cap_rdy", 8'(cap_rdy), 8'h00);
    check("ovf", 8'(ovf), 8'h01);
    for (int i = 0; i < 32; i++) pop_check(8'(i));
    check("cap_vld", 8'(cap_vld), 8'h00);
    clear_pulse(MODE_INPUT);
    check("ovf", 8'(ovf), 8'h00);
  endtask : t_fifo_fill

  initial begin
    repeat (20) @(posedge clock_in);
    #1 resetn_in = 1'h1;
    t_reset_values();
    wcyc(4);
    t_input_mode();
    t_output_mode();
    t_fifo_fill();
    report_and_stop();
  end
endmodule : tb_top

bind mbp_port mbp_port_checker u_chk (.clock_in, .resetn_in, .strobe_in, .select_first_in, .select_second_in,
  .clear_n_in, .mode_in, .byte_in_bus_in, .byte_out_bus_out, .byte_out_en_n_out, .service_request_out);
